// ===== core/fault_diag_params.svh
// constants of the four-channel speaker fault diagnostics block
// Function
// R1: turn-on pulse classifies each output fault
// R2: turn-on result kept until re-armed read
// R3: pulse first, stage off, outputs high-z
// R4: after bias, permanent diagnostics replace result
// R5: latch status at pulse plateau end
// R6: short classification independent of gain setting
// R7: low gain plus line option selects limits
// R8: permanent diagnostics never report open load
// R9: restart mode: faulted channel off, 1ms recheck
// R10: host enables diagnostic mode, overload activates
// R11: recheck after 1ms, clear means resume
// R12: persisting overload starts 100ms diagnostic cycle
// R13: after cycle: restart mode, store, await read
// R14: host polls results, over half second
// R15: offset window opens at read/enable, closes
// R16: offset flagged only if persistent whole window
// R17: overload suppresses offset and ac results
// R18: ac test enable and threshold select bits
// R19: fewer than three peaks flags open tweeter
// R20: host plays tone at least three cycles
// R21: multiple faults reported over successive reads
// R22: shorts win over load faults, both shorts
// R23: read restarts cycles, returns previous data
// R24: status bytes updated only at cycle end
`ifndef FAULT_DIAG_PARAMS_SVH
`define FAULT_DIAG_PARAMS_SVH
`define CLK_MHZ          200
`define ACQ_TIME_MS      100
`define RECHECK_TIME_US  1000
`define DIAG_TIME_MS     100
`define CNT_W            25
`define NCH              4
`define AC_PEAKS_MIN     2'h3
`define ADDR_IB1         8'h00
`define ADDR_IB2         8'h04
`define ADDR_FAULT       8'h08
`define ADDR_TEST        8'h0c
`define IB1_STBY_EXIT    0
`define IB1_DIAG_EN      1
`define IB1_GAIN_LOW     2
`define IB1_LINE_DIAG    3
`define IB1_OFS_EN       5
`define IB2_AC_EN        2
`define IB2_AC_THR       7
`define IB1_RST          8'h00
`define IB2_RST          8'h00
`endif

// ===== core/fault_diag_pkg.sv
// types of the speaker fault diagnostics block
`include "fault_diag_params.svh"
package fault_diag_pkg;
	typedef logic [`CNT_W-1:0] cnt_t;
	typedef enum logic [1:0] {
		TO_IDLE   = 2'b00,
		TO_PULSE  = 2'b01,
		TO_BIASED = 2'b10
	} to_state_t;
	typedef enum logic [1:0] {
		CH_ACTIVE  = 2'b00,
		CH_WAIT    = 2'b01,
		CH_DIAG    = 2'b10,
		CH_RESTART = 2'b11
	} ch_state_t;
	typedef struct packed {
		logic short_gnd;
		logic short_vs;
		logic shorted_load;
		logic open_load;
		logic overload;
		logic offset_high;
		logic ac_peak;
	} sense_t;
	typedef struct packed {
		logic open_load;
		logic shorted_load;
		logic short_vs;
		logic short_gnd;
	} fault_t;
endpackage : fault_diag_pkg

// ===== core/speaker_fault_diagnostics.sv
// four-channel output diagnostics sequencer with ahb-lite registers
//
// Added by the designer: the register offsets and the AHB-Lite slave port.
`include "fault_diag_params.svh"
module speaker_fault_diagnostics #(
	parameter int unsigned ACQ_CYC     = `ACQ_TIME_MS * 1000 * `CLK_MHZ,
	parameter int unsigned RECHECK_CYC = `RECHECK_TIME_US * `CLK_MHZ,
	parameter int unsigned DIAG_CYC    = `DIAG_TIME_MS * 1000 * `CLK_MHZ
) (
	// clock and reset
	input  wire logic                          hclk,
	input  wire logic                          hresetn,
	// ahb-lite slave
	input  wire logic                          hsel,
	input  wire logic [31:0]                   haddr,
	input  wire logic [1:0]                    htrans,
	input  wire logic                          hwrite,
	input  wire logic [2:0]                    hsize,
	input  wire logic [31:0]                   hwdata,
	input  wire logic                          hready,
	output logic      [31:0]                   hrdata,
	output logic                               hreadyout,
	output logic                               hresp,
	// comparator inputs per channel
	input  wire fault_diag_pkg::sense_t [3:0]  sense,
	// power stage and analog controls
	output logic      [3:0]                    test_pulse,
	output logic      [3:0]                    stage_on,
	output logic                               outputs_hiz,
	output logic                               line_limits,
	output logic                               ac_threshold
);
	import fault_diag_pkg::*;

	typedef struct packed {
		sense_t    [3:0]       s1;
		sense_t    [3:0]       s2;
		logic      [3:0]       peak_d;
		logic                  wr_pend;
		logic      [7:0]       wr_addr;
		logic      [31:0]      rdata;
		logic      [7:0]       ib1;
		logic      [7:0]       ib2;
		to_state_t             to;
		cnt_t                  to_cnt;
		logic                  to_armed;
		logic      [3:0]       perm_armed;
		ch_state_t [3:0]       ch;
		cnt_t      [3:0]       ch_cnt;
		fault_t    [3:0]       live;
		fault_t    [3:0]       shown;
		logic                  ofs_open;
		logic      [3:0]       ofs_persist;
		logic      [3:0]       ofs_shown;
		logic      [3:0][1:0]  peaks;
		logic      [3:0]       ac_ovl;
		logic      [3:0]       ac_open;
		logic      [3:0]       pulse_q;
		logic      [3:0]       stage_q;
		logic                  hiz_q;
		logic                  line_q;
		logic                  thr_q;
	} state_t;

	state_t st_r;
	state_t st_nxt;
	logic   acc;
	logic   rd_evt;

	// R6 R22 shorts ignore gain setting
	function automatic fault_t classify(input sense_t s, input logic with_open);
		fault_t f;
		f = '0;
		if (s.short_gnd || s.short_vs) begin
			f.short_gnd = s.short_gnd;
			f.short_vs  = s.short_vs;
		end else if (s.shorted_load) begin
			f.shorted_load = 1'b1;
		end else begin
			f.open_load = with_open & s.open_load;
		end
		return f;
	endfunction : classify

	function automatic logic [1:0] sat_inc(input logic [1:0] v);
		return (v == `AC_PEAKS_MIN) ? v : v + 2'h1;
	endfunction : sat_inc

	// one status byte per channel, code in the low nibble
	function automatic logic [31:0] fault_word(input fault_t [3:0] f);
		return {4'h0, f[3], 4'h0, f[2], 4'h0, f[1], 4'h0, f[0]};
	endfunction : fault_word

	assign acc    = hsel && hready && htrans[1] && (hsize == 3'h2);
	assign rd_evt = acc && !hwrite && (haddr[7:0] == `ADDR_FAULT);

	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = sense;
		st_nxt.s2 = st_r.s1;
		for (int c = 0; c < `NCH; c++) begin
			st_nxt.peak_d[c] = st_r.s2[c].ac_peak;
		end
		// bus address phase and read mux
		st_nxt.wr_pend = acc && hwrite;
		st_nxt.wr_addr = haddr[7:0];
		if (acc && !hwrite) begin
			case (haddr[7:0])
				`ADDR_IB1:   st_nxt.rdata = {24'h0, st_r.ib1};
				`ADDR_IB2:   st_nxt.rdata = {24'h0, st_r.ib2};
				`ADDR_FAULT: st_nxt.rdata = fault_word(st_r.shown);
				`ADDR_TEST:  st_nxt.rdata = {18'h0, st_r.to, 4'h0, st_r.ac_open, st_r.ofs_shown};
				default:     st_nxt.rdata = 32'h0;
			endcase
		end
		if (st_r.wr_pend && st_r.wr_addr == `ADDR_IB1) begin
			st_nxt.ib1 = hwdata[7:0];
		end
		if (st_r.wr_pend && st_r.wr_addr == `ADDR_IB2) begin
			st_nxt.ib2 = hwdata[7:0];
		end
		// R2 R21 R23 read re-arms cycles
		if (rd_evt) begin
			st_nxt.shown      = st_r.live;
			st_nxt.live       = '0;
			st_nxt.to_armed   = 1'b1;
			st_nxt.perm_armed = 4'hf;
			// R15 window closes here
			st_nxt.ofs_shown   = st_r.ofs_open ? st_r.ofs_persist : 4'h0;
			st_nxt.ofs_persist = 4'hf;
			st_nxt.ofs_open    = st_r.ib1[`IB1_OFS_EN];
			// R19 peak count verdict
			for (int c = 0; c < `NCH; c++) begin
				st_nxt.ac_open[c] = st_r.ib2[`IB2_AC_EN] && !st_r.ac_ovl[c]
					&& (st_r.peaks[c] != `AC_PEAKS_MIN);
			end
			st_nxt.peaks  = '0;
			st_nxt.ac_ovl = '0;
		end
		// R15 window opens on enable
		if (st_nxt.ib1[`IB1_OFS_EN] && !st_r.ib1[`IB1_OFS_EN]) begin
			st_nxt.ofs_open    = 1'b1;
			st_nxt.ofs_persist = 4'hf;
		end else if (!st_nxt.ib1[`IB1_OFS_EN]) begin
			st_nxt.ofs_open = 1'b0;
		end
		// R18 ac test restarts on enable
		if (st_nxt.ib2[`IB2_AC_EN] && !st_r.ib2[`IB2_AC_EN]) begin
			st_nxt.peaks  = '0;
			st_nxt.ac_ovl = '0;
		end
		for (int c = 0; c < `NCH; c++) begin
			// R16 offset must persist
			if (st_r.ofs_open && !st_r.s2[c].offset_high) begin
				st_nxt.ofs_persist[c] = 1'b0;
			end
			// R17 overload suppresses both
			if (st_r.s2[c].overload) begin
				st_nxt.ofs_persist[c] = 1'b0;
				if (st_r.ib2[`IB2_AC_EN]) begin
					st_nxt.ac_ovl[c] = 1'b1;
				end
			end
			// R19 count current peaks
			if (st_r.ib2[`IB2_AC_EN] && st_r.s2[c].ac_peak && !st_r.peak_d[c]) begin
				st_nxt.peaks[c] = sat_inc(st_nxt.peaks[c]);
			end
		end
		// R3 standby exit with diag enable
		if (st_r.wr_pend && st_r.wr_addr == `ADDR_IB1) begin
			if (!hwdata[`IB1_STBY_EXIT]) begin
				st_nxt.to = TO_IDLE;
			end else if (!st_r.ib1[`IB1_STBY_EXIT]) begin
				if (hwdata[`IB1_DIAG_EN] && st_r.to_armed) begin
					st_nxt.to       = TO_PULSE;
					st_nxt.to_cnt   = '0;
					st_nxt.to_armed = 1'b0;
				end else begin
					st_nxt.to = TO_BIASED;
				end
			end
		end else if (st_r.to == TO_PULSE) begin
			st_nxt.to_cnt = st_r.to_cnt + cnt_t'(1);
			// R5 latch at plateau end
			if (st_r.to_cnt == cnt_t'(ACQ_CYC - 1)) begin
				st_nxt.to = TO_BIASED;
				for (int c = 0; c < `NCH; c++) begin
					// R1 R22 turn-on classification
					st_nxt.live[c] = classify(st_r.s2[c], 1'b1);
				end
			end
		end
		for (int c = 0; c < `NCH; c++) begin
			if (st_r.to != TO_BIASED) begin
				st_nxt.ch[c]     = CH_ACTIVE;
				st_nxt.ch_cnt[c] = '0;
			end else begin
				st_nxt.ch_cnt[c] = st_r.ch_cnt[c] + cnt_t'(1);
				case (st_r.ch[c])
					CH_ACTIVE: begin
						st_nxt.ch_cnt[c] = '0;
						// R10 overload self-activates
						if (st_r.s2[c].overload) begin
							st_nxt.ch[c] = st_r.ib1[`IB1_DIAG_EN] ? CH_WAIT : CH_RESTART;
						end
					end
					CH_WAIT: begin
						// R11 recheck after 1ms
						if (st_r.ch_cnt[c] == cnt_t'(RECHECK_CYC - 1)) begin
							st_nxt.ch_cnt[c] = '0;
							if (!st_r.s2[c].overload) begin
								st_nxt.ch[c] = CH_ACTIVE;
							end else if (st_r.perm_armed[c]) begin
								// R12 start diagnostic cycle
								st_nxt.ch[c] = CH_DIAG;
							end else begin
								st_nxt.ch[c] = CH_RESTART;
							end
						end
					end
					CH_DIAG: begin
						if (st_r.ch_cnt[c] == cnt_t'(DIAG_CYC - 1)) begin
							// R13 store and restart
							st_nxt.ch_cnt[c]     = '0;
							st_nxt.ch[c]         = CH_RESTART;
							st_nxt.perm_armed[c] = 1'b0;
							// R4 R8 R24 permanent result
							st_nxt.live[c] = classify(st_r.s2[c], 1'b0);
						end
					end
					CH_RESTART: begin
						// R9 periodic restart check
						if (st_r.ch_cnt[c] == cnt_t'(RECHECK_CYC - 1)) begin
							st_nxt.ch_cnt[c] = '0;
							if (!st_r.s2[c].overload) begin
								st_nxt.ch[c] = CH_ACTIVE;
							end
						end
					end
					default: st_nxt.ch[c] = CH_ACTIVE;
				endcase
			end
			st_nxt.pulse_q[c] = (st_nxt.to == TO_PULSE);
			st_nxt.stage_q[c] = (st_nxt.to == TO_BIASED) && (st_nxt.ch[c] == CH_ACTIVE);
		end
		st_nxt.hiz_q  = (st_nxt.to != TO_BIASED);
		// R7 line driver limit set
		st_nxt.line_q = st_nxt.ib1[`IB1_GAIN_LOW] && st_nxt.ib1[`IB1_LINE_DIAG];
		st_nxt.thr_q  = st_nxt.ib2[`IB2_AC_THR];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r            <= '0;
			st_r.ib1        <= `IB1_RST;
			st_r.ib2        <= `IB2_RST;
			st_r.to         <= TO_IDLE;
			st_r.to_armed   <= 1'b1;
			st_r.perm_armed <= 4'hf;
			st_r.hiz_q      <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign hrdata       = st_r.rdata;
	assign hreadyout    = 1'b1;
	assign hresp        = 1'b0;
	assign test_pulse   = st_r.pulse_q;
	assign stage_on     = st_r.stage_q;
	assign outputs_hiz  = st_r.hiz_q;
	assign line_limits  = st_r.line_q;
	assign ac_threshold = st_r.thr_q;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	property p_pulse_hiz;
		(st_r.to == TO_PULSE) |-> outputs_hiz && (stage_on == 4'h0) && (test_pulse == 4'hf);
	endproperty
	a_pulse_hiz: assert property (p_pulse_hiz) else $error("stage not off during pulse"); // R3

	property p_plateau_latch;
		(st_r.to == TO_PULSE) && (st_r.to_cnt == cnt_t'(ACQ_CYC - 1)) && !st_r.wr_pend
			|=> (st_r.live[0] == classify($past(st_r.s2[0]), 1'b1)) && (st_r.to == TO_BIASED);
	endproperty
	a_plateau_latch: assert property (p_plateau_latch) else $error("turn-on latch wrong"); // R5

	property p_short_priority;
		(st_r.live[1].short_gnd || st_r.live[1].short_vs)
			|-> !st_r.live[1].shorted_load && !st_r.live[1].open_load;
	endproperty
	a_short_priority: assert property (p_short_priority) else $error("short lost priority"); // R22

	property p_restart_off;
		(st_r.ch[0] == CH_RESTART) && (st_r.to == TO_BIASED) |-> !stage_on[0];
	endproperty
	a_restart_off: assert property (p_restart_off) else $error("restart channel driven"); // R9

	property p_recheck_clear;
		(st_r.to == TO_BIASED) && (st_r.ch[0] == CH_WAIT) && !st_r.wr_pend
			&& (st_r.ch_cnt[0] == cnt_t'(RECHECK_CYC - 1)) && !st_r.s2[0].overload
			|=> (st_r.ch[0] == CH_ACTIVE) && stage_on[0];
	endproperty
	a_recheck_clear: assert property (p_recheck_clear) else $error("channel not resumed"); // R11

	property p_recheck_diag;
		(st_r.to == TO_BIASED) && (st_r.ch[0] == CH_WAIT) && !st_r.wr_pend
			&& (st_r.ch_cnt[0] == cnt_t'(RECHECK_CYC - 1)) && st_r.s2[0].overload
			&& st_r.perm_armed[0] |=> (st_r.ch[0] == CH_DIAG) && (st_r.ch_cnt[0] == '0);
	endproperty
	a_recheck_diag: assert property (p_recheck_diag) else $error("diag cycle not started"); // R12

	property p_diag_end;
		(st_r.to == TO_BIASED) && (st_r.ch[0] == CH_DIAG) && !st_r.wr_pend
			&& (st_r.ch_cnt[0] == cnt_t'(DIAG_CYC - 1)) && !rd_evt
			|=> (st_r.ch[0] == CH_RESTART) && !st_r.perm_armed[0] && !st_r.live[0].open_load;
	endproperty
	a_diag_end: assert property (p_diag_end) else $error("diag end handling wrong"); // R13

	property p_read_shows_prev;
		rd_evt && !st_r.wr_pend |=> (st_r.shown == $past(st_r.live)) && st_r.to_armed
			&& (hrdata == fault_word($past(st_r.shown)));
	endproperty
	a_read_shows_prev: assert property (p_read_shows_prev) else $error("read exchange wrong"); // R23

	property p_offset_verdict;
		rd_evt |=> (st_r.ofs_shown == ($past(st_r.ofs_open) ? $past(st_r.ofs_persist) : 4'h0));
	endproperty
	a_offset_verdict: assert property (p_offset_verdict) else $error("offset verdict wrong"); // R16

	property p_ac_verdict;
		rd_evt && st_r.ib2[`IB2_AC_EN] && (st_r.peaks[2] == `AC_PEAKS_MIN) |=> !st_r.ac_open[2];
	endproperty
	a_ac_verdict: assert property (p_ac_verdict) else $error("tweeter wrongly open"); // R19

	property p_ac_suppress;
		rd_evt && st_r.ac_ovl[3] |=> !st_r.ac_open[3];
	endproperty
	a_ac_suppress: assert property (p_ac_suppress) else $error("ac result not suppressed"); // R17

	c_turn_on: cover property ((st_r.to == TO_PULSE) ##1 (st_r.to == TO_BIASED));
	c_diag_cycle: cover property ((st_r.ch[0] == CH_DIAG) ##1 (st_r.ch[0] == CH_RESTART));
	c_resume: cover property ((st_r.ch[1] == CH_WAIT) ##1 (st_r.ch[1] == CH_ACTIVE));
	c_open_tweeter: cover property (rd_evt ##1 (st_r.ac_open != 4'h0));

endmodule : speaker_fault_diagnostics

// ===== tb/ahb_host_model.sv
// host model that drives the ahb-lite register bus
module ahb_host_model (
	// clock
	input  wire logic        hclk,
	// ahb-lite master side
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
	end

	// single word transfer, holds each phase until hready
	task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
			output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, addr};
		htrans <= 2'b10;
		hwrite <= wr;
		hsize <= 3'b010;
		do begin
			@(posedge hclk);
		end while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do begin
			@(posedge hclk);
		end while (hready !== 1'b1);
		rd = hrdata;
	endtask : xfer

	task automatic host_read2(output logic [31:0] rd);
		logic [31:0] tmp;
		xfer(1'b0, 8'h08, 32'h0, tmp);
		xfer(1'b0, 8'h08, 32'h0, rd);
	endtask : host_read2
endmodule : ahb_host_model

// ===== tb/tb_speaker_fault_diagnostics.sv
// self-checking bench of the speaker fault diagnostics block
module tb_speaker_fault_diagnostics;
	timeunit 1ns;
	timeprecision 1ps;
	import fault_diag_pkg::*;
	localparam int RCK = 10;
	localparam int DGC = 30;
	typedef struct packed {
		logic [7:0]  ib1;
		logic [15:0] flt;
		logic [31:0] exp;
	} row_t;
	localparam row_t rows [4] = '{
		'{8'h03, 16'h8421, 32'h08040201},
		'{8'h07, 16'h9a53, 32'h01020103},
		'{8'h0f, 16'h0000, 32'h00000000},
		'{8'h0b, 16'h4806, 32'h04080002}
	};
	logic         hclk;
	logic         hresetn;
	logic         hsel;
	logic [31:0]  haddr;
	logic [1:0]   htrans;
	logic         hwrite;
	logic [2:0]   hsize;
	logic [31:0]  hwdata;
	logic [31:0]  hrdata;
	logic         hreadyout;
	logic         hresp;
	sense_t [3:0] sense;
	logic [3:0]   test_pulse;
	logic [3:0]   stage_on;
	logic         outputs_hiz;
	logic         line_limits;
	logic         ac_threshold;
	logic [31:0]  rd;
	logic [3:0]   pk;
	int           bad_count;
	int           checks;

	speaker_fault_diagnostics #(.ACQ_CYC(20), .RECHECK_CYC(RCK), .DIAG_CYC(DGC))
	u_speaker_fault_diagnostics (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .sense(sense), .test_pulse(test_pulse), .stage_on(stage_on),
		.outputs_hiz(outputs_hiz), .line_limits(line_limits), .ac_threshold(ac_threshold));

	ahb_host_model u_ahb_host_model (.hclk(hclk), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata));

	initial hclk = 1'b0;
	always #2.5 hclk = ~hclk;

	function automatic sense_t mk(input logic [3:0] f);
		sense_t s;
		s = '0;
		s.open_load = f[3];
		s.shorted_load = f[2];
		s.short_vs = f[1];
		s.short_gnd = f[0];
		return s;
	endfunction : mk

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", nm, exp, got);
			bad_count++;
		end
	endtask : chk

	task automatic test_done;
		if (bad_count == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : test_done

	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] t;
		u_ahb_host_model.xfer(1'b1, a, d, t);
	endtask : wr

	task automatic rdr(input logic [7:0] a, output logic [31:0] d);
		u_ahb_host_model.xfer(1'b0, a, 32'h0, d);
	endtask : rdr

	initial begin
		hresetn = 1'b0;
		sense = '0;
		bad_count = 0;
		checks = 0;
		cyc(4);
		chk("reset outputs", 32'h1004, {19'h0, hreadyout, hresp, test_pulse, stage_on,
			outputs_hiz, line_limits, ac_threshold});
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		rdr(8'h00, rd);
		chk("ib1 reset", 32'h0, rd);
		rdr(8'h04, rd);
		chk("ib2 reset", 32'h0, rd);
		rdr(8'h40, rd);
		chk("unmapped", 32'h0, rd);
		wr(8'h08, 32'hff);
		rdr(8'h08, rd);
		chk("fault ro", 32'h0, rd);
		foreach (rows[i]) begin
			@(posedge hclk);
			sense <= {mk(rows[i].flt[15:12]), mk(rows[i].flt[11:8]),
				mk(rows[i].flt[7:4]), mk(rows[i].flt[3:0])};
			wr(8'h00, 32'h0);
			wr(8'h00, {24'h0, rows[i].ib1});
			cyc(5);
			chk("pulse", 32'h1e1, {23'h0, test_pulse, stage_on, outputs_hiz});
			cyc(25);
			chk("biased", {31'h1e, rows[i].ib1[2] & rows[i].ib1[3]},
				{22'h0, test_pulse, stage_on, outputs_hiz, line_limits});
			u_ahb_host_model.host_read2(rd);
			chk("turn-on", rows[i].exp, rd & 32'h0f0f0f0f);
		end
		@(posedge hclk);
		sense <= '0;
		wr(8'h00, 32'h03);
		u_ahb_host_model.host_read2(rd);
		@(posedge hclk);
		sense <= {7'h00, 7'h04, 7'h1c, 7'h00};
		cyc(3);
		@(posedge hclk);
		sense[2].overload <= 1'b0;
		cyc(5);
		chk("trip", 32'h9, {28'h0, stage_on});
		cyc(RCK + 6);
		chk("recheck", 32'hd, {28'h0, stage_on});
		cyc(DGC + 5);
		u_ahb_host_model.host_read2(rd);
		chk("permanent", 32'h400, rd & 32'h0f0f0f0f);
		@(posedge hclk);
		sense <= {7'h00, 7'h02, 7'h02, 7'h02};
		cyc(2 * RCK + 8);
		chk("restart", 32'hf, {28'h0, stage_on});
		wr(8'h00, 32'h21);
		cyc(6);
		@(posedge hclk);
		sense <= {7'h00, 7'h06, 7'h00, 7'h02};
		cyc(3);
		@(posedge hclk);
		sense[2].overload <= 1'b0;
		cyc(4);
		chk("no diag trip", 32'hb, {28'h0, stage_on});
		cyc(2 * RCK + 8);
		chk("no diag resume", 32'hf, {28'h0, stage_on});
		rdr(8'h08, rd);
		rdr(8'h0c, rd);
		chk("offset", 32'h1, rd & 32'h0f);
		@(posedge hclk);
		sense <= '0;
		wr(8'h04, 32'h84);
		cyc(3);
		chk("ac threshold", 32'h1, {31'h0, ac_threshold});
		for (int p = 0; p < 4; p++) begin
			pk = {1'b1, 1'b0, p < 2, p < 3};
			@(posedge hclk);
			sense <= {6'h0, pk[3], 6'h0, pk[2], 6'h0, pk[1], 6'h0, pk[0]};
			cyc(4);
			@(posedge hclk);
			sense <= '0;
			cyc(4);
		end
		rdr(8'h08, rd);
		rdr(8'h0c, rd);
		chk("tweeter", 32'h60, rd & 32'hf0);
		wr(8'h04, 32'h00);
		cyc(3);
		chk("ac threshold", 32'h0, {31'h0, ac_threshold});
		test_done();
	end

	initial begin
		repeat (20000) @(posedge hclk);
		bad_count++;
		test_done();
	end
endmodule : tb_speaker_fault_diagnostics
